// ### rtl/rdt_pkg.sv
package rdt_pkg;
	// ==========================================================
	// sizing
	localparam int unsigned SENSOR_COUNT = 5;
	localparam int unsigned BUTTON_COUNT = 3;
	localparam int unsigned TIME_W = 16;
	localparam int unsigned STAMP_W = 8;

	// ==========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned TICK_PERIOD_NS = 400;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned CHARGE_TIME_NS = 10000;
	localparam int unsigned CHARGE_CYCLES = (CHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TIMEOUT_COUNTS = 2000;

	// ==========================================================
	// reset values
	localparam logic [TIME_W-1:0] TIME_RESET = 16'h0000;
	localparam logic [STAMP_W-1:0] STAMP_RESET = 8'h00;

	// ==========================================================
	// result carrier
	typedef struct packed {
		logic valid;
		logic [SENSOR_COUNT*TIME_W-1:0] times;
	} rdt_result_type;
endpackage

// ### rtl/rdt_timer.sv
// Operation
// - drive all lines high to charge, then release as inputs and start timing
// - time base counts up once every 0.4 us during a measurement
// - elapsed time sums unsigned counter differences so wraparound is harmless
// - record elapsed time on a falling input only if nothing recorded yet
// - inspect sensors only when port sample differs from previous sample
// - stop when elapsed reaches timeout limit, default 2000, then present results
// - time all five sensor lines together, one time per sensor
// - button reads 1 released and 0 pressed
// - pull-up enable on button inputs is always asserted
module rdt_timer #(
	parameter int unsigned SENSORS = rdt_pkg::SENSOR_COUNT,
	parameter int unsigned BUTTONS = rdt_pkg::BUTTON_COUNT,
	parameter int unsigned CHARGE_CYC = rdt_pkg::CHARGE_CYCLES,
	parameter logic [rdt_pkg::TIME_W-1:0] TIMEOUT_LIMIT = 16'h07D0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic start,
	output logic busy,
	// sensor lines, two-way
	input wire logic [SENSORS-1:0] sensor_in,
	output logic [SENSORS-1:0] sensor_out,
	output logic [SENSORS-1:0] sensor_oe,
	// pushbuttons
	input wire logic [BUTTONS-1:0] button_in,
	output logic [BUTTONS-1:0] button_pullup_en,
	output logic [BUTTONS-1:0] button_level,
	// result
	output rdt_pkg::rdt_result_type result
);
	localparam int unsigned TW = rdt_pkg::TIME_W;
	localparam int unsigned SW = rdt_pkg::STAMP_W;
	localparam int unsigned TICK_W = $clog2(rdt_pkg::TICK_CYCLES + 1);
	localparam int unsigned CHG_W = $clog2(CHARGE_CYC + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(rdt_pkg::TICK_CYCLES - 1);
	localparam logic [CHG_W-1:0] CHG_LAST = CHG_W'(CHARGE_CYC - 1);

	typedef enum logic [1:0] {RDT_IDLE, RDT_CHARGE, RDT_TIME} rdt_state_type;

	// ==========================================================
	// pin synchronisers: three stages, change accepted when 2 and 3 agree
	logic [SENSORS-1:0] s1_q, s2_q, s3_q, s_clean_q;
	logic [BUTTONS-1:0] b1_q, b2_q, b3_q, b_clean_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			b1_q <= '1;
			b2_q <= '1;
			b3_q <= '1;
		end else begin
			s1_q <= sensor_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			b1_q <= button_in;
			b2_q <= b1_q;
			b3_q <= b2_q;
		end
	end

	wire [SENSORS-1:0] s_agree = ~(s2_q ^ s3_q);
	wire [BUTTONS-1:0] b_agree = ~(b2_q ^ b3_q);
	wire [SENSORS-1:0] s_clean_d = (s_agree & s3_q) | (~s_agree & s_clean_q);
	wire [BUTTONS-1:0] b_clean_d = (b_agree & b3_q) | (~b_agree & b_clean_q);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_clean_q <= '0;
			b_clean_q <= '1;
		end else begin
			s_clean_q <= s_clean_d;
			b_clean_q <= b_clean_d;
		end
	end

	// ==========================================================
	// pushbuttons: active-low level, pull-up always on
	assign button_pullup_en = '1;
	assign button_level = b_clean_q;

	// ==========================================================
	// state and time base
	rdt_state_type state_q, state_d;
	logic [CHG_W-1:0] chg_q;
	logic [TICK_W-1:0] tick_q;
	logic [SW-1:0] stamp_q, last_stamp_q;
	logic [TW-1:0] elapsed_q;
	logic [SENSORS-1:0] last_port_q;
	logic [SENSORS-1:0][TW-1:0] rec_q;
	logic [SENSORS*TW-1:0] out_times_q;
	logic out_valid_q;

	wire timing = (state_q == RDT_TIME);
	wire tick_wrap = (tick_q == TICK_LAST);
	wire chg_done = (chg_q == CHG_LAST);
	// unsigned narrow difference never goes negative across a wrap
	wire [SW-1:0] delta = stamp_q - last_stamp_q;
	wire [TW-1:0] elapsed_d = elapsed_q + TW'(delta);
	wire timed_out = (elapsed_d >= TIMEOUT_LIMIT);
	wire port_changed = (s_clean_q != last_port_q);
	wire [SENSORS-1:0] falling = last_port_q & ~s_clean_q;

	// next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			RDT_IDLE: if (start) state_d = RDT_CHARGE;
			RDT_CHARGE: if (chg_done) state_d = RDT_TIME;
			RDT_TIME: if (timed_out) state_d = RDT_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) state_q <= RDT_IDLE;
		else state_q <= state_d;
	end

	// charge counter held at zero outside charge, tick prescaler held at zero outside timing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chg_q <= '0;
			tick_q <= '0;
			stamp_q <= rdt_pkg::STAMP_RESET;
		end else begin
			chg_q <= (state_q == RDT_CHARGE) ? chg_q + CHG_W'(1) : '0;
			tick_q <= (!timing || tick_wrap) ? '0 : tick_q + TICK_W'(1);
			if (timing && tick_wrap) stamp_q <= stamp_q + SW'(1);
		end
	end

	// elapsed accumulator follows the counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			elapsed_q <= rdt_pkg::TIME_RESET;
			last_stamp_q <= rdt_pkg::STAMP_RESET;
			last_port_q <= '0;
		end else if (timing) begin
			elapsed_q <= elapsed_d;
			last_stamp_q <= last_stamp_q + delta;
			if (port_changed) last_port_q <= s_clean_q;
		end else begin
			elapsed_q <= rdt_pkg::TIME_RESET;
			last_stamp_q <= stamp_q;
			last_port_q <= '1; // lines were charged high
		end
	end

	// per-sensor capture, all sensors timed together
	for (genvar i = 0; i < SENSORS; i++) begin : g_sensor
		wire cap = timing && port_changed && falling[i] && (rec_q[i] == '0);
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) rec_q[i] <= rdt_pkg::TIME_RESET;
			else if (state_q == RDT_CHARGE) rec_q[i] <= rdt_pkg::TIME_RESET;
			else if (cap) rec_q[i] <= (elapsed_d == '0) ? TW'(1) : elapsed_d;
		end
		// unresolved sensors report the limit
		wire [TW-1:0] fin = (rec_q[i] == '0) ? TIMEOUT_LIMIT : rec_q[i];
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) out_times_q[i*TW +: TW] <= rdt_pkg::TIME_RESET;
			else if (timing && timed_out) out_times_q[i*TW +: TW] <= fin;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) out_valid_q <= 1'b0;
		else if (start && state_q == RDT_IDLE) out_valid_q <= 1'b0;
		else if (timing && timed_out) out_valid_q <= 1'b1;
	end

	// ==========================================================
	// pin drive: high during charge, released otherwise
	assign sensor_oe = {SENSORS{state_q == RDT_CHARGE}};
	assign sensor_out = '1;
	assign busy = (state_q != RDT_IDLE);
	assign result.valid = out_valid_q;
	assign result.times = out_times_q;

	// ==========================================================
	// checks
	sequence s_charge_end;
		state_q == RDT_CHARGE && chg_done;
	endsequence
	property p_release;
		@(posedge clk) disable iff (!rst_n) s_charge_end |=> (sensor_oe == '0) && timing;
	endproperty
	a_release: assert property (p_release) else $error("lines not released after charge");
	property p_charge_drive;
		@(posedge clk) disable iff (!rst_n) (state_q == RDT_CHARGE) |-> (sensor_oe == '1);
	endproperty
	a_charge_drive: assert property (p_charge_drive) else $error("lines not driven in charge");
	property p_tick;
		@(posedge clk) disable iff (!rst_n) (timing && tick_wrap) |=> timing |-> stamp_q == $past(stamp_q) + SW'(1);
	endproperty
	a_tick: assert property (p_tick) else $error("time base did not advance");
	property p_mono;
		@(posedge clk) disable iff (!rst_n) timing && $past(timing) |-> elapsed_q >= $past(elapsed_q);
	endproperty
	a_mono: assert property (p_mono) else $error("elapsed time went backwards");
	property p_keep;
		@(posedge clk) disable iff (!rst_n) timing && rec_q[0] != '0 |=> rec_q[0] == $past(rec_q[0]);
	endproperty
	a_keep: assert property (p_keep) else $error("recorded time overwritten");
	property p_nochange;
		@(posedge clk) disable iff (!rst_n) timing && !port_changed |=> $stable(rec_q);
	endproperty
	a_nochange: assert property (p_nochange) else $error("capture without port change");
	property p_end;
		@(posedge clk) disable iff (!rst_n) timing && timed_out |=> !busy && result.valid;
	endproperty
	a_end: assert property (p_end) else $error("measurement did not end at limit");
	property p_limit;
		@(posedge clk) disable iff (!rst_n) $rose(result.valid) |-> result.times[TW-1:0] != '0;
	endproperty
	a_limit: assert property (p_limit) else $error("zero time reported");
	property p_button;
		@(posedge clk) disable iff (!rst_n) (b2_q == b3_q) |=> button_level == $past(b3_q);
	endproperty
	a_button: assert property (p_button) else $error("button level wrong");
endmodule // rdt_timer

// ### test/rdt_sensor_model.sv
module rdt_sensor_model (
	// clock
	input wire logic clk,
	// pin side of the timer
	input wire logic [4:0] drive_val,
	input wire logic [4:0] drive_oe,
	// per-sensor discharge time in clocks after release
	input wire logic [79:0] fall_cyc,
	// wire level seen by the timer
	output logic [4:0] line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cap_q = 5'h00;
	logic [15:0] cnt_q [5];
	// =====================================
	// capacitor charges while driven, then holds 1 until the light drains it
	always @(posedge clk) begin
		for (int i = 0; i < 5; i++) begin
			if (drive_oe[i]) begin
				cap_q[i] <= drive_val[i];
				cnt_q[i] <= 16'h0000;
			end else if (cnt_q[i] < fall_cyc[16*i +: 16]) begin
				cnt_q[i] <= cnt_q[i] + 16'h0001;
			end else begin
				cap_q[i] <= 1'b0; // drained line is low, never left at the last value
			end
		end
	end
	// the driver wins over the capacitor while enabled
	assign line = (drive_oe & drive_val) | (~drive_oe & cap_q);
endmodule // rdt_sensor_model

// ### test/reflectance_discharge_timer_tb.sv
module reflectance_discharge_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] LIM = 16'h0014;
	// shortened charge time handed to the timer
	localparam int CHG = 4;
	// model drain edge, three sync flops and the clean flop before a fall is seen
	localparam int LAT = 5;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic start = 1'b0;
	logic busy;
	logic [4:0] s_in, s_out, s_oe;
	logic [2:0] b_in = 3'h7;
	logic [2:0] b_pu, b_lvl;
	rdt_pkg::rdt_result_type result;
	logic [79:0] fall = '1;
	int failures = 0;
	int n_compared = 0;
	// =====================================
	always #2 clk = ~clk;
	rdt_timer #(.CHARGE_CYC(CHG), .TIMEOUT_LIMIT(LIM)) dut_u (.clk(clk), .rst_n(rst_n),
		.start(start), .busy(busy), .sensor_in(s_in), .sensor_out(s_out), .sensor_oe(s_oe),
		.button_in(b_in), .button_pullup_en(b_pu), .button_level(b_lvl), .result(result));
	rdt_sensor_model model_u (.clk(clk), .drive_val(s_out), .drive_oe(s_oe),
		.fall_cyc(fall), .line(s_in));
	// =====================================
	task automatic tally_and_finish();
		if (failures == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_bits(logic [7:0] got, logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// the time base phase is fixed by the end of charge, so times compare exactly
	task automatic chk_time(logic [15:0] got, logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// int arithmetic so a never-falling 16'hFFFF cannot wrap to a small time
	function automatic logic [15:0] exp_time(logic [15:0] d);
		int q;
		q = (int'(d) + LAT) / int'(rdt_pkg::TICK_CYCLES);
		if (q >= int'(LIM)) return LIM;
		return (q == 0) ? 16'h0001 : 16'(q);
	endfunction
	// one measurement with the given discharge delays
	task automatic measure(logic [79:0] f);
		int n;
		@(posedge clk);
		fall <= f;
		b_in <= 3'($urandom);
		start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		#1 chk_bits({7'h00, busy}, 8'h01);
		chk_bits({7'h00, result.valid}, 8'h00);
		chk_bits({3'h0, s_oe}, 8'h1F);
		chk_bits({3'h0, s_out}, 8'h1F);
		chk_bits({5'h00, b_pu}, 8'h07);
		repeat (20) @(posedge clk);
		start <= 1'b1; // ignored while busy
		#1 chk_bits({3'h0, s_oe}, 8'h00);
		// buttons pass three sync flops, so they are only compared once settled
		chk_bits({5'h00, b_lvl}, {5'h00, b_in});
		@(posedge clk) start <= 1'b0;
		#1 n = 21;
		while (busy === 1'b1 && n < 4000) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 4000) begin
			failures++;
			tally_and_finish();
		end
		// charge, then limit ticks, then one edge for busy to drop
		chk_time(16'(n), 16'(CHG + int'(LIM) * int'(rdt_pkg::TICK_CYCLES) + 1));
		repeat (2) @(posedge clk);
		#1 chk_bits({7'h00, result.valid}, 8'h01);
		for (int i = 0; i < 5; i++) begin
			chk_time(result.times[16*i +: 16], exp_time(f[16*i +: 16]));
		end
	endtask
	// =====================================
	initial begin
		void'($urandom(32'h6b875ebd));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		measure({16'hFFFF, 16'h06D6, 16'h03E8, 16'h0032, 16'h0000});
		// falls that land on the limit edge, one cycle before it and on tick edges
		measure({16'h07CB, 16'h07CA, 16'h00C3, 16'h00C2, 16'h0001});
		for (int k = 0; k < 4; k++) begin
			measure({16'($urandom_range(1700)), 16'($urandom_range(1700)),
				16'($urandom_range(1700)), 16'($urandom_range(1700)), 16'hFFFF});
		end
		tally_and_finish();
	end
endmodule // reflectance_discharge_timer_tb
